/* File: rtl/mod_clock_pkg.sv */
// constants, tables and carriers for the modulator clock control block
package mod_clock_pkg;
   // register addresses on the serial configuration port
   localparam logic [7:0] ENABLE_ADDR = 8'h09;
   localparam logic [7:0] SETUP_ADDR = 8'h0a;
   // field positions
   localparam int ENABLE_BIT = 2;
   localparam int AUTOBAND_BIT = 6;
   localparam int LOCK_BIT = 7;
   localparam int FACTOR_W = 6;
   localparam int STRAP_W = 5;
   // reset values
   localparam logic [7:0] ENABLE_RESET = 8'h00;
   localparam logic [6:0] SETUP_RESET = 7'h00;
   // strap code that selects direct clocking
   localparam logic [4:0] STRAP_DIRECT = 5'h1f;
   localparam logic [4:0] STRAP_LAST_LISTED = 5'h10;
   // supported factors, ascending
   localparam int FACTOR_COUNT = 18;
   localparam logic [5:0] FACTOR_TABLE [FACTOR_COUNT] = '{
      6'h08, 6'h09, 6'h0a, 6'h0c, 6'h0e, 6'h0f, 6'h10, 6'h11, 6'h12,
      6'h14, 6'h15, 6'h18, 6'h19, 6'h1c, 6'h1e, 6'h20, 6'h22, 6'h2a};
   // lock acquisition time of the oscillator loop
   localparam int CLK_PERIOD_PS = 5000;
   localparam int LOCK_TIME_NS = 10000;
   localparam int LOCK_CYCLES =
      (LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int COUNT_W = 12;
   // writable fields of the setup register
   typedef struct packed {
      logic autoband;
      logic [FACTOR_W-1:0] factor;
   } setup_t;
   // lock sequencer states
   typedef enum logic [1:0] {BYPASS, ACQUIRE, LOCKED} lock_state_t;
endpackage

/* File: rtl/mod_clock_control.sv */
// modulator clock source selection, factor decode and lock reporting
`timescale 1ns/1ps
module mod_clock_control
   import mod_clock_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [STRAP_W-1:0] factor_strap_pins,
   output logic [7:0] reg_rdata,
   output logic multiplier_active,
   output logic [FACTOR_W-1:0] multiplication_factor,
   output logic autoband_en,
   output logic locked,
   output logic mod_clk
);

   // checks below share this clock and reset
   default clocking check_cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // strap code to factor
   function automatic logic [5:0] strap_factor(input logic [4:0] code);
      if (code <= STRAP_LAST_LISTED)
         return FACTOR_TABLE[code[4:0]];
      return FACTOR_TABLE[FACTOR_COUNT-1];
   endfunction

   // register field to largest supported factor not above it; fields below 8 map to 8
   function automatic logic [5:0] reg_factor(input logic [5:0] v);
      logic [5:0] r;
      r = FACTOR_TABLE[0];
      for (int i = 0; i < FACTOR_COUNT; i++)
         if (v >= FACTOR_TABLE[i])
            r = FACTOR_TABLE[i];
      return r;
   endfunction

   logic serial_active;
   logic [7:0] enable_reg;
   setup_t setup;
   lock_state_t state;
   logic [COUNT_W-1:0] lock_count;
   logic [5:0] applied_factor;
   logic mult_on;
   logic [5:0] factor_sel;

   // source of control: straps until first serial access
   always_comb
   begin
      if (serial_active)
      begin
         mult_on = enable_reg[ENABLE_BIT];
         factor_sel = reg_factor(setup.factor);
      end
      else
      begin
         mult_on = (factor_strap_pins != STRAP_DIRECT);
         factor_sel = strap_factor(factor_strap_pins);
      end
   end

   // source selection checks
   strap_bypass_a: assert property (
      !serial_active && factor_strap_pins == 5'h1f
      |=> !multiplier_active)
      else $error("strap code 31 did not bypass multiplier");
   strap_decode_a: assert property (
      !serial_active && factor_strap_pins == 5'h14
      |=> multiplication_factor == 6'h2a)
      else $error("strap code 20 not decoded to 42");
   strap_low_a: assert property (
      !serial_active && factor_strap_pins == 5'h03
      |=> multiplication_factor == 6'h0c)
      else $error("strap code 3 not decoded to 12");
   reg_decode_a: assert property (
      serial_active && setup.factor == 6'h17
      |=> multiplication_factor == 6'h15)
      else $error("factor 23 not mapped to 21");
   zero_factor_a: assert property (
      serial_active && setup.factor == 6'h00
      |=> multiplication_factor == 6'h08)
      else $error("factor 0 not mapped to 8");
   reset_bypass_a: assert property (
      serial_active && !enable_reg[ENABLE_BIT]
      |=> !multiplier_active)
      else $error("multiplier active without enable");

   // serial control wakes on the first access of either kind
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         serial_active <= 1'b0;
      else if (reg_wr || reg_rd)
         serial_active <= 1'b1;
   end

   // first access check
   serial_wake_a: assert property (
      !serial_active && reg_wr |=> serial_active)
      else $error("serial control did not wake on first access");

   // register writes; lock bit is not writable
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         enable_reg <= ENABLE_RESET;
         setup <= SETUP_RESET;
      end
      else if (reg_wr)
      begin
         if (reg_addr == ENABLE_ADDR)
            enable_reg <= reg_wdata;
         else if (reg_addr == SETUP_ADDR)
            setup <= reg_wdata[6:0];
      end
   end

   // register reads; unmapped addresses read zero
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         if (reg_addr == ENABLE_ADDR)
            reg_rdata <= enable_reg;
         else if (reg_addr == SETUP_ADDR)
            reg_rdata <= {locked, setup};
         else
            reg_rdata <= 8'h00;
      end
   end

   // lock bit readback check
   lock_read_a: assert property (
      reg_rd && reg_addr == SETUP_ADDR |=> reg_rdata[7] == $past(locked))
      else $error("lock bit readback wrong");

   // lock sequencer: restart on enable or any factor change
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state <= BYPASS;
         lock_count <= '0;
         applied_factor <= FACTOR_TABLE[0];
         locked <= 1'b0;
      end
      else if (!mult_on)
      begin
         state <= BYPASS;
         locked <= 1'b0;
      end
      else if (state == BYPASS || factor_sel != applied_factor)
      begin
         state <= ACQUIRE;
         lock_count <= COUNT_W'(LOCK_CYCLES - 1);
         applied_factor <= factor_sel;
         locked <= 1'b0;
      end
      else
      begin
         unique case (state)
            ACQUIRE:
            begin
               if (lock_count == '0)
               begin
                  state <= LOCKED;
                  locked <= 1'b1;
               end
               else
                  lock_count <= lock_count - 1'b1;
            end
            LOCKED:
               locked <= 1'b1;
            BYPASS:
               locked <= 1'b0;
         endcase
      end
   end

   // lock sequencer checks
   lock_clear_a: assert property (
      !mult_on || (locked && factor_sel != applied_factor)
      |=> !locked)
      else $error("lock bit not cleared on disable or factor change");
   lock_rise_a: assert property (
      $rose(locked)
      |-> $past(state) == ACQUIRE && $past(lock_count) == '0)
      else $error("lock reported before acquisition finished");

   // outputs toward the analog clock path
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         multiplier_active <= 1'b0;
         multiplication_factor <= FACTOR_TABLE[0];
         autoband_en <= 1'b0;
      end
      else
      begin
         multiplier_active <= mult_on;
         multiplication_factor <= factor_sel;
         autoband_en <= serial_active ? setup.autoband : 1'b1;
      end
   end

   // halve the oscillator rate: toggle each cycle, 50% duty
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         mod_clk <= 1'b0;
      else if (multiplier_active)
         mod_clk <= ~mod_clk;
      else
         mod_clk <= 1'b0;
   end

   // halved clock check
   clock_half_a: assert property (
      multiplier_active |=> mod_clk != $past(mod_clk))
      else $error("modulator clock not halved");

   // main scenarios
   serial_lock_c: cover property (serial_active && $rose(locked));
   strap_lock_c: cover property (!serial_active && $rose(locked));
   relock_c: cover property (locked && factor_sel != applied_factor);
   direct_c: cover property (
      !serial_active && factor_strap_pins == 5'h1f);
endmodule

/* File: tb/config_host.sv */
// configuration host model for the serial register port
`timescale 1ns/1ps
module config_host
   import mod_clock_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // one byte access, strobe held for a single cycle
   task automatic access(input logic wr, input logic [7:0] a,
      input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a; // released lines carry junk
      reg_wdata <= ~d;
      #1 q = reg_rdata;
   endtask
   // factor first, then enable; reference of 30 to 160 MHz runs already
   task automatic bring_up(input logic [7:0] setup);
      logic [7:0] q;
      access(1'b1, SETUP_ADDR, setup, q);
      access(1'b1, ENABLE_ADDR, 8'h04, q);
   endtask
   // new factor: drop enable, then bring up again
   task automatic refactor(input logic [7:0] setup);
      logic [7:0] q;
      access(1'b1, ENABLE_ADDR, 8'h00, q);
      bring_up(setup);
   endtask
endmodule

/* File: tb/test_modulator_clock_multiplier_control.sv */
// self-checking bench for the modulator clock control block
`timescale 1ns/1ps
module test_modulator_clock_multiplier_control
   import mod_clock_pkg::*;
;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [4:0] straps = 5'h00;
   logic reg_wr, reg_rd, mult_on, auto_on, lock_on, mclk, b, m;
   logic [7:0] addr, wdata, rdata, q;
   logic [5:0] factor;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int sup[$] = '{8, 9, 10, 12, 14, 15, 16, 17, 18, 20, 21, 24, 25, 28,
      30, 32, 34, 42};
   always #2.5 clk = ~clk;
   config_host host_u (.clk(clk), .reg_rdata(rdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata));
   mod_clock_control dut_u (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata),
      .factor_strap_pins(straps), .reg_rdata(rdata),
      .multiplier_active(mult_on), .multiplication_factor(factor),
      .autoband_en(auto_on), .locked(lock_on), .mod_clk(mclk));
   // largest supported factor not above v; 8 when v is below 8
   function automatic int reg_map(int v);
      int n = 8;
      foreach (sup[i])
         if (sup[i] <= v)
            n = sup[i];
      return n;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      if (got !== exp)
         err_count++;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic finish_test;
      $display("errors %0d checks %0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         finish_test;
      end
   end
   initial
   begin
      void'($urandom(32'he072));
      wait_n(11);
      chk(8'({mult_on, auto_on, lock_on, mclk}), 8'h00);
      chk(8'(factor), 8'h08);
      @(posedge clk);
      reset_n <= 1'b1;
      // strap mode, every code
      for (int s = 0; s < 32; s++)
      begin
         @(posedge clk);
         straps <= 5'(s);
         wait_n(3);
         chk(8'(mult_on), 8'(s != 31));
         chk(8'(auto_on), 8'h01);
         if (s != 31)
            chk(8'(factor), 8'(s <= 16 ? sup[s] : 42));
         m = mclk;
         wait_n(1);
         chk(8'(mclk), 8'(m ^ (s != 31)));
      end
      @(posedge clk);
      straps <= 5'h05;
      wait_n(3);
      // strap mode reaches lock on its own, shown in the first read
      wait_n(LOCK_CYCLES);
      chk(8'(lock_on), 8'h01);
      host_u.access(1'b0, SETUP_ADDR, 8'h00, q);
      chk(q, 8'h80);
      wait_n(3);
      chk(8'(mult_on), 8'h00);
      // every register factor, lock bit not writable
      for (int v = 0; v < 64; v++)
      begin
         b = 1'($urandom);
         host_u.access(1'b1, SETUP_ADDR, {1'b1, b, 6'(v)}, q);
         host_u.access(1'b0, SETUP_ADDR, 8'h00, q);
         chk(q, {1'b0, b, 6'(v)});
         chk(8'(factor), 8'(reg_map(v)));
         chk(8'(auto_on), 8'(b));
      end
      host_u.bring_up(8'h59);
      wait_n(3);
      chk(8'({mult_on, factor}), 8'h59);
      wait_n(LOCK_CYCLES - 10);
      chk(8'(lock_on), 8'h00);
      wait_n(20);
      host_u.access(1'b1, SETUP_ADDR, 8'h59, q);
      host_u.access(1'b0, SETUP_ADDR, 8'h00, q);
      chk(q, 8'hd9);
      host_u.access(1'b1, SETUP_ADDR, 8'h48, q);
      wait_n(2);
      chk(8'(lock_on), 8'h00);
      host_u.refactor(8'h48);
      wait_n(LOCK_CYCLES + 10);
      chk(8'({lock_on, factor}), 8'h48);
      // unmapped place, full enable byte
      host_u.access(1'b1, 8'h0b, 8'hff, q);
      host_u.access(1'b0, 8'h0b, 8'h00, q);
      chk(q, 8'h00);
      host_u.access(1'b0, ENABLE_ADDR, 8'h00, q);
      chk(q, 8'h04);
      host_u.access(1'b1, ENABLE_ADDR, 8'h00, q);
      wait_n(3);
      chk(8'({mult_on, lock_on, mclk}), 8'h00);
      finish_test;
   end
endmodule
